// [rtl/daapls_pkg.sv]
package daapls_pkg;

  // ==========================================================
  // Register numbers on the control port
  // ==========================================================
  localparam logic [5:0] DAAPLS_REG_PWR      = 6'h06;   // Power control
  localparam logic [5:0] DAAPLS_REG_STAT     = 6'h0C;   // Link status
  localparam logic [5:0] DAAPLS_REG_LINE_A   = 6'h10;   // Hook speed, ringer, threshold
  localparam logic [5:0] DAAPLS_REG_CAL      = 6'h11;   // ADC calibration control
  localparam logic [5:0] DAAPLS_REG_RCAL     = 6'h19;   // Resistor calibration control
  localparam logic [5:0] DAAPLS_REG_DCTERM   = 6'h1A;   // DC termination
  localparam logic [5:0] DAAPLS_REG_ACTERM   = 6'h1E;   // AC termination, level
  localparam logic [5:0] DAAPLS_REG_LINE_B   = 6'h1F;   // Second hook speed bit
  localparam logic [5:0] DAAPLS_REG_PCM      = 6'h21;   // PCM mode
  localparam logic [5:0] DAAPLS_REG_GCI      = 6'h2A;   // GCI mode

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int DAAPLS_BIT_SLEEP    = 3;   // system_sleep_req in power register
  localparam int DAAPLS_BIT_LSPD     = 4;   // line_side_powerdown in power register
  localparam int DAAPLS_BIT_FDT      = 6;   // frame_detect_flag in status register
  localparam int DAAPLS_BIT_RESISTOR_CAL_DISABLE    = 5;   // resistor_cal_disable
  localparam int DAAPLS_BIT_AUTO_ADC_CAL_DISABLE     = 4;   // auto_adc_cal_disable
  localparam int DAAPLS_BIT_MANUAL_CAL_TRIGGER     = 5;   // manual_cal_trigger
  localparam int DAAPLS_BIT_CALBUSY  = 7;   // Calibration busy, read only
  localparam int DAAPLS_BIT_PLLLOCK  = 7;   // PLL locked, read only in power register

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic [7:0] DAAPLS_PWR_RESET  = 8'h10;   // Line side powered down, sleep clear
  localparam logic [7:0] DAAPLS_ZERO_RESET = 8'h00;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int DAAPLS_CLK_MHZ       = 100;
  localparam int DAAPLS_PLL_LOCK_US   = 1000;    // 1 ms
  localparam int DAAPLS_RCAL_US       = 17000;   // 17 ms
  localparam int DAAPLS_ADCCAL_US     = 256000;  // 256 ms
  localparam int DAAPLS_PLL_LOCK_CYC  = DAAPLS_PLL_LOCK_US * DAAPLS_CLK_MHZ;
  localparam int DAAPLS_RCAL_CYC      = DAAPLS_RCAL_US * DAAPLS_CLK_MHZ;
  localparam int DAAPLS_ADCCAL_CYC    = DAAPLS_ADCCAL_US * DAAPLS_CLK_MHZ;
  localparam int DAAPLS_PCLK_EDGES    = 4;       // Bit clock edges seen before lock

  // ==========================================================
  // Power modes
  // ==========================================================
  typedef enum logic [3:0] {
    DAAPLS_MODE_RESET  = 4'b0001,
    DAAPLS_MODE_NORMAL = 4'b0010,
    DAAPLS_MODE_SLEEP  = 4'b0100,
    DAAPLS_MODE_DEEP   = 4'b1000
  } daapls_mode_type;

endpackage

// [rtl/daapls_link_if.sv]
`timescale 1ns/100ps
// Control port and clock pins between host and device
interface daapls_link_if;
  logic       reset_n;      // Device reset pin, active low
  logic       bit_clk;      // Bit clock from host
  logic       frame_sync;   // Frame sync from host
  logic [5:0] addr;         // Register number
  logic [7:0] wdata;        // Write data
  logic       wr;           // Write strobe
  logic       rd;           // Read strobe
  logic [7:0] rdata;        // Read data, cycle after rd

  modport host (
    output reset_n,
    output bit_clk,
    output frame_sync,
    output addr,
    output wdata,
    output wr,
    output rd,
    input  rdata
  );

  modport device (
    input  reset_n,
    input  bit_clk,
    input  frame_sync,
    input  addr,
    input  wdata,
    input  wr,
    input  rd,
    output rdata
  );
endinterface

// [rtl/daapls_device.sv]
`timescale 1ns/100ps
module daapls_device
  import daapls_pkg::*;
#(
  parameter int PLL_LOCK_CYC = DAAPLS_PLL_LOCK_CYC,
  parameter int RCAL_CYC     = DAAPLS_RCAL_CYC,
  parameter int ADCCAL_CYC   = DAAPLS_ADCCAL_CYC
) (
  input  wire logic   clk_i,
  input  wire logic   reset_i,
  daapls_link_if.device link,
  input  wire logic   offhook_i,        // Hook state from line side
  input  wire logic   line_power_lost_i,// Line power collapse event
  input  wire logic   frame_seen_i,     // Line side answering frames
  input  wire logic   ring_i,           // Raw ring from line side
  output logic        link_enable_o,    // Link carries traffic
  output logic        ring_detect_out_o,// Ring detect output, active high
  output logic        cal_busy_o,       // Any calibration running
  output logic [3:0]  mode_o            // One-hot power mode
);

  // ==========================================================
  // Synchronisers for the pins
  // ==========================================================
  logic [1:0] rstn_sync_reg;   // Reset pin
  logic [1:0] pclk_sync_reg;   // Bit clock
  logic [1:0] fs_sync_reg;     // Frame sync
  logic [1:0] fdt_sync_reg;    // Frame seen
  logic [1:0] ring_sync_reg;   // Ring
  logic       pclk_last_reg;   // Previous synced bit clock
  logic       fs_last_reg;     // Previous synced frame sync

  // Two flip-flops on the reset, bit clock, frame sync, frame seen and ring inputs
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rstn_sync_reg <= 2'h0;
      pclk_sync_reg <= 2'h0;
      fs_sync_reg   <= 2'h0;
      fdt_sync_reg  <= 2'h0;
      ring_sync_reg <= 2'h0;
      pclk_last_reg <= 1'b0;
      fs_last_reg   <= 1'b0;
    end else begin
      rstn_sync_reg <= {rstn_sync_reg[0], link.reset_n};
      pclk_sync_reg <= {pclk_sync_reg[0], link.bit_clk};
      fs_sync_reg   <= {fs_sync_reg[0], link.frame_sync};
      fdt_sync_reg  <= {fdt_sync_reg[0], frame_seen_i};
      ring_sync_reg <= {ring_sync_reg[0], ring_i};
      pclk_last_reg <= pclk_sync_reg[1];
      fs_last_reg   <= fs_sync_reg[1];
    end
  end

  logic dev_rst;   // Chip reset: system reset or pin held low
  logic pclk_rise; // Bit clock rising edge
  logic fs_rise;   // Frame sync rising edge
  assign dev_rst   = reset_i | ~rstn_sync_reg[1];
  assign pclk_rise = pclk_sync_reg[1] & ~pclk_last_reg;
  assign fs_rise   = fs_sync_reg[1] & ~fs_last_reg;

  // ==========================================================
  // Registers
  // ==========================================================
  logic [7:0] pwr_reg;     // Power control
  logic [7:0] line_a_reg;  // onhook_speed_sel, ringer_impedance_sel, ring_threshold_sel
  logic [7:0] cal_reg;     // auto_adc_cal_disable, manual_cal_trigger
  logic [7:0] rcal_reg;    // resistor_cal_disable
  logic [7:0] dcterm_reg;  // current_limit_en, dc_term_voltage_sel, min_loop_current_sel
  logic [7:0] acterm_reg;  // ac_impedance_sel, double_level_sel
  logic [7:0] line_b_reg;  // onhook_speed_sel_b
  logic [7:0] pcm_reg;     // PCM mode
  logic [7:0] gci_reg;     // GCI mode
  logic       pll_lock_reg;
  logic       frame_detect_flag;
  daapls_mode_type mode_reg;

  logic sleep_req;      // system_sleep_req
  logic lsp_down;       // line_side_powerdown
  assign sleep_req = pwr_reg[DAAPLS_BIT_SLEEP];
  assign lsp_down  = pwr_reg[DAAPLS_BIT_LSPD];

  logic wr_ok;          // Writes are refused in sleep and deep powerdown
  assign wr_ok = link.wr & (mode_reg != DAAPLS_MODE_SLEEP) & (mode_reg != DAAPLS_MODE_DEEP);

  // Register writes; every default keeps the line side down
  always_ff @(posedge clk_i) begin
    if (dev_rst) begin
      pwr_reg    <= DAAPLS_PWR_RESET;
      line_a_reg <= DAAPLS_ZERO_RESET;
      cal_reg    <= DAAPLS_ZERO_RESET;
      rcal_reg   <= DAAPLS_ZERO_RESET;
      dcterm_reg <= DAAPLS_ZERO_RESET;
      acterm_reg <= DAAPLS_ZERO_RESET;
      line_b_reg <= DAAPLS_ZERO_RESET;
      pcm_reg    <= DAAPLS_ZERO_RESET;
      gci_reg    <= DAAPLS_ZERO_RESET;
    end else if (wr_ok) begin
      case (link.addr)
        DAAPLS_REG_PWR:    pwr_reg    <= {3'h0, link.wdata[4:3], 3'h0};
        DAAPLS_REG_LINE_A: line_a_reg <= link.wdata;
        DAAPLS_REG_CAL:    cal_reg    <= {2'h0, link.wdata[5:4], 4'h0};
        DAAPLS_REG_RCAL:   rcal_reg   <= {2'h0, link.wdata[5], 5'h0};
        DAAPLS_REG_DCTERM: dcterm_reg <= link.wdata;
        DAAPLS_REG_ACTERM: acterm_reg <= link.wdata;
        DAAPLS_REG_LINE_B: line_b_reg <= link.wdata;
        DAAPLS_REG_PCM:    pcm_reg    <= link.wdata;
        DAAPLS_REG_GCI:    gci_reg    <= link.wdata;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // PLL lock model: counts from first bit clock edge
  // ==========================================================
  logic [31:0] pll_cnt_reg;
  logic [2:0]  edge_cnt_reg;
  always_ff @(posedge clk_i) begin
    if (dev_rst) begin
      pll_cnt_reg  <= 32'h0000_0000;
      edge_cnt_reg <= 3'h0;
      pll_lock_reg <= 1'b0;
    end else if (!pll_lock_reg) begin
      // Lock timer runs from the first bit clock edge, so the bound holds from clock arrival
      if (pclk_rise && edge_cnt_reg != 3'(DAAPLS_PCLK_EDGES)) begin
        edge_cnt_reg <= edge_cnt_reg + 3'h1;
      end
      if (edge_cnt_reg != 3'h0) begin
        pll_cnt_reg <= pll_cnt_reg + 32'h0000_0001;
        if ((fs_rise && edge_cnt_reg == 3'(DAAPLS_PCLK_EDGES)) || pll_cnt_reg == 32'(PLL_LOCK_CYC - 1)) begin
          pll_lock_reg <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Power mode from the two bits
  // ==========================================================
  always_ff @(posedge clk_i) begin
    if (dev_rst) begin
      mode_reg <= DAAPLS_MODE_RESET;
    end else begin
      case (mode_reg)
        DAAPLS_MODE_DEEP:  mode_reg <= DAAPLS_MODE_DEEP;
        DAAPLS_MODE_SLEEP: mode_reg <= DAAPLS_MODE_SLEEP;
        default: begin
          if (sleep_req && lsp_down) begin
            mode_reg <= DAAPLS_MODE_DEEP;
          end else if (sleep_req) begin
            mode_reg <= DAAPLS_MODE_SLEEP;
          end else if (!lsp_down) begin
            mode_reg <= DAAPLS_MODE_NORMAL;
          end else begin
            mode_reg <= DAAPLS_MODE_RESET;
          end
        end
      endcase
    end
  end

  // Link runs only with line side powered and not in deep powerdown
  assign link_enable_o = ~lsp_down & (mode_reg != DAAPLS_MODE_DEEP)
                         & (mode_reg != DAAPLS_MODE_RESET);
  assign frame_detect_flag = link_enable_o & fdt_sync_reg[1];

  // Ring output only with valid frames; dead in deep powerdown
  always_ff @(posedge clk_i) begin
    if (dev_rst) begin
      ring_detect_out_o <= 1'b0;
    end else begin
      ring_detect_out_o <= ring_sync_reg[1] & frame_detect_flag;
    end
  end

  // ==========================================================
  // Calibration sequencer
  // ==========================================================
  typedef enum logic [2:0] {
    CAL_IDLE = 3'b001,
    CAL_RES  = 3'b010,
    CAL_ADC  = 3'b100
  } daapls_cal_type;
  daapls_cal_type cal_state_reg;
  logic [31:0] cal_cnt_reg;
  logic        hook_last_reg;
  logic        manual_cal_trigger_last_reg;
  logic        offhook_rise;
  logic        manual_cal_trigger_fall;
  logic        cal_run;
  assign offhook_rise = offhook_i & ~hook_last_reg;
  assign manual_cal_trigger_fall    = manual_cal_trigger_last_reg & ~cal_reg[DAAPLS_BIT_MANUAL_CAL_TRIGGER];
  assign cal_run      = mode_reg == DAAPLS_MODE_NORMAL;

  always_ff @(posedge clk_i) begin
    if (dev_rst) begin
      hook_last_reg <= 1'b0;
      manual_cal_trigger_last_reg <= 1'b0;
    end else begin
      hook_last_reg <= offhook_i;
      manual_cal_trigger_last_reg <= cal_reg[DAAPLS_BIT_MANUAL_CAL_TRIGGER];
    end
  end

  // Automatic resistor then ADC calibration, or manual ADC only
  always_ff @(posedge clk_i) begin
    if (dev_rst) begin
      cal_state_reg <= CAL_IDLE;
      cal_cnt_reg   <= 32'h0000_0000;
    end else begin
      case (cal_state_reg)
        CAL_IDLE: begin
          cal_cnt_reg <= 32'h0000_0000;
          if (cal_run && (offhook_rise || line_power_lost_i)) begin
            if (rcal_reg[DAAPLS_BIT_RESISTOR_CAL_DISABLE]) begin
              if (!cal_reg[DAAPLS_BIT_AUTO_ADC_CAL_DISABLE]) begin
                cal_state_reg <= CAL_ADC;
              end
            end else begin
              cal_state_reg <= CAL_RES;
            end
          end else if (cal_run && manual_cal_trigger_fall && cal_reg[DAAPLS_BIT_AUTO_ADC_CAL_DISABLE]) begin
            cal_state_reg <= CAL_ADC;
          end
        end
        CAL_RES: begin
          cal_cnt_reg <= cal_cnt_reg + 32'h0000_0001;
          if (cal_cnt_reg == 32'(RCAL_CYC - 1)) begin
            cal_cnt_reg   <= 32'h0000_0000;
            cal_state_reg <= cal_reg[DAAPLS_BIT_AUTO_ADC_CAL_DISABLE] ? CAL_IDLE : CAL_ADC;
          end
        end
        CAL_ADC: begin
          cal_cnt_reg <= cal_cnt_reg + 32'h0000_0001;
          if (cal_cnt_reg == 32'(ADCCAL_CYC - 1)) begin
            cal_state_reg <= CAL_IDLE;
          end
        end
        default: cal_state_reg <= CAL_IDLE;
      endcase
    end
  end
  assign cal_busy_o = cal_state_reg != CAL_IDLE;
  assign mode_o     = mode_reg;

  // ==========================================================
  // Read data, one cycle after the strobe
  // ==========================================================
  always_ff @(posedge clk_i) begin
    if (dev_rst) begin
      link.rdata <= 8'h00;
    end else if (link.rd) begin
      case (link.addr)
        DAAPLS_REG_PWR:    link.rdata <= {pll_lock_reg, pwr_reg[6:0]};
        DAAPLS_REG_STAT:   link.rdata <= {1'b0, frame_detect_flag, 6'h00};
        DAAPLS_REG_LINE_A: link.rdata <= line_a_reg;
        DAAPLS_REG_CAL:    link.rdata <= {cal_busy_o, cal_reg[6:0]};
        DAAPLS_REG_RCAL:   link.rdata <= rcal_reg;
        DAAPLS_REG_DCTERM: link.rdata <= dcterm_reg;
        DAAPLS_REG_ACTERM: link.rdata <= acterm_reg;
        DAAPLS_REG_LINE_B: link.rdata <= line_b_reg;
        DAAPLS_REG_PCM:    link.rdata <= pcm_reg;
        DAAPLS_REG_GCI:    link.rdata <= gci_reg;
        default:           link.rdata <= 8'h00;
      endcase
    end
  end

endmodule

// [rtl/daapls_host.sv]
`timescale 1ns/100ps
module daapls_host
  import daapls_pkg::*;
#(
  parameter int PLL_LOCK_CYC = DAAPLS_PLL_LOCK_CYC,
  parameter int CLK_DIV      = 8,     // Half period of bit clock in clk cycles
  parameter int FS_DIV       = 32     // Bit clocks per frame
) (
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  daapls_link_if.host     link,
  input  wire logic       start_i,      // Run the init sequence
  input  wire logic       use_gci_i,    // Select GCI rather than PCM
  input  wire logic       sleep_i,      // Request sleep after init
  input  wire logic [7:0] line_a_i,     // Country field values
  input  wire logic [7:0] dcterm_i,
  input  wire logic [7:0] acterm_i,
  input  wire logic [7:0] line_b_i,
  input  wire logic       manual_cal_trigger_i,       // Request manual ADC calibration
  output logic            done_o,       // Sequence finished
  output logic [7:0]      status_o      // Last read value
);

  // ==========================================================
  // Bit clock and frame sync, kept running always
  // ==========================================================
  logic [15:0] div_cnt_reg;
  logic [7:0]  fs_cnt_reg;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      div_cnt_reg     <= 16'h0000;
      fs_cnt_reg      <= 8'h00;
      link.bit_clk    <= 1'b0;
      link.frame_sync <= 1'b0;
    end else if (div_cnt_reg == 16'(CLK_DIV - 1)) begin
      div_cnt_reg  <= 16'h0000;
      link.bit_clk <= ~link.bit_clk;
      if (link.bit_clk) begin
        fs_cnt_reg      <= (fs_cnt_reg == 8'(FS_DIV - 1)) ? 8'h00 : fs_cnt_reg + 8'h01;
        link.frame_sync <= fs_cnt_reg == 8'h00;
      end
    end else begin
      div_cnt_reg <= div_cnt_reg + 16'h0001;
    end
  end

  // ==========================================================
  // Init sequence
  // ==========================================================
  typedef enum logic [9:0] {
    H_RESET = 10'b00_0000_0001,
    H_IDLE  = 10'b00_0000_0010,
    H_LOCK  = 10'b00_0000_0100,
    H_MODE  = 10'b00_0000_1000,
    H_LA    = 10'b00_0001_0000,
    H_DC    = 10'b00_0010_0000,
    H_AC    = 10'b00_0100_0000,
    H_LB    = 10'b00_1000_0000,
    H_PWR   = 10'b01_0000_0000,
    H_DONE  = 10'b10_0000_0000
  } daapls_host_type;
  daapls_host_type st_reg;
  logic [31:0] wait_reg;
  logic [1:0]  manual_cal_trigger_step_reg;
  logic        rd_last_reg;   // Read strobe seen last cycle

  // Drive pins and step through the documented order
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st_reg        <= H_RESET;
      wait_reg      <= 32'h0000_0000;
      manual_cal_trigger_step_reg <= 2'h0;
      link.reset_n  <= 1'b0;
      link.addr     <= 6'h00;
      link.wdata    <= 8'h00;
      link.wr       <= 1'b0;
      link.rd       <= 1'b0;
      done_o        <= 1'b0;
    end else begin
      link.wr <= 1'b0;
      link.rd <= 1'b0;
      case (st_reg)
        H_RESET: begin
          wait_reg <= wait_reg + 32'h0000_0001;
          if (wait_reg == 32'h0000_0010) begin
            link.reset_n <= 1'b1;
            st_reg       <= H_IDLE;
          end
        end
        H_IDLE: begin
          wait_reg <= 32'h0000_0000;
          if (start_i) begin
            st_reg <= H_LOCK;
          end
        end
        H_LOCK: begin
          // Give the lock its full time, then confirm the lock bit by polling
          wait_reg  <= wait_reg + 32'h0000_0001;
          link.addr <= DAAPLS_REG_PWR;
          if (wait_reg >= 32'(PLL_LOCK_CYC) && rd_last_reg && link.rdata[DAAPLS_BIT_PLLLOCK]) begin
            st_reg <= H_MODE;
          end else begin
            link.rd <= 1'b1;
          end
        end
        H_MODE: begin
          link.wr    <= 1'b1;
          link.addr  <= use_gci_i ? DAAPLS_REG_GCI : DAAPLS_REG_PCM;
          link.wdata <= 8'h01;
          st_reg     <= H_LA;
        end
        H_LA: begin
          link.wr <= 1'b1; link.addr <= DAAPLS_REG_LINE_A; link.wdata <= line_a_i;
          st_reg  <= H_DC;
        end
        H_DC: begin
          link.wr <= 1'b1; link.addr <= DAAPLS_REG_DCTERM; link.wdata <= dcterm_i;
          st_reg  <= H_AC;
        end
        H_AC: begin
          link.wr <= 1'b1; link.addr <= DAAPLS_REG_ACTERM; link.wdata <= acterm_i;
          st_reg  <= H_LB;
        end
        H_LB: begin
          link.wr <= 1'b1; link.addr <= DAAPLS_REG_LINE_B; link.wdata <= line_b_i;
          st_reg  <= H_PWR;
        end
        H_PWR: begin
          link.wr    <= 1'b1;
          link.addr  <= DAAPLS_REG_PWR;
          link.wdata <= 8'h00;
          st_reg     <= H_DONE;
        end
        H_DONE: begin
          done_o <= 1'b1;
          // Manual cal: disable auto, raise trigger, drop it
          if (manual_cal_trigger_i && manual_cal_trigger_step_reg == 2'h0) begin
            link.wr <= 1'b1; link.addr <= DAAPLS_REG_CAL; link.wdata <= 8'h10;
            manual_cal_trigger_step_reg <= 2'h1;
          end else if (manual_cal_trigger_step_reg == 2'h1) begin
            link.wr <= 1'b1; link.addr <= DAAPLS_REG_CAL; link.wdata <= 8'h30;
            manual_cal_trigger_step_reg <= 2'h2;
          end else if (manual_cal_trigger_step_reg == 2'h2) begin
            link.wr <= 1'b1; link.addr <= DAAPLS_REG_CAL; link.wdata <= 8'h10;
            manual_cal_trigger_step_reg <= 2'h3;
          end else if (sleep_i) begin
            link.wr <= 1'b1; link.addr <= DAAPLS_REG_PWR; link.wdata <= 8'h08;
          end else begin
            link.rd <= 1'b1; link.addr <= DAAPLS_REG_STAT;
          end
          if (!manual_cal_trigger_i && manual_cal_trigger_step_reg == 2'h3) begin
            manual_cal_trigger_step_reg <= 2'h0;
          end
        end
        default: st_reg <= H_RESET;
      endcase
    end
  end

  // Capture read data the cycle after a read
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rd_last_reg <= 1'b0;
      status_o    <= 8'h00;
    end else begin
      rd_last_reg <= link.rd;
      if (rd_last_reg) begin
        status_o <= link.rdata;
      end
    end
  end

endmodule

// [testbench/daapls_asserts.sv]
`timescale 1ns/100ps
// ====================
// Control port and bit clock checks
module daapls_asserts
  import daapls_pkg::*;
#(
  parameter int PLL_LOCK_CYC = DAAPLS_PLL_LOCK_CYC,
  parameter int CLK_DIV      = 8
) (
  input wire logic       clk_i,
  input wire logic       reset_i,
  input wire logic       reset_n,
  input wire logic       bit_clk,
  input wire logic       frame_sync,
  input wire logic [5:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata
);
  logic        mode_reg;    // Interface mode written
  logic        pwr_reg;     // Power register written
  logic [17:0] up_reg;      // Cycles since reset pin release
  logic        bclk_d_reg;  // Bit clock one cycle ago
  logic [7:0]  bclk_reg;    // Cycles since bit clock moved
  logic        rdpwr_reg;   // Power register read last cycle
  logic        lock_reg;    // Host has read the lock bit set
  // Host progress since the device left reset
  always_ff @(posedge clk_i) begin
    if (reset_i || !reset_n) begin
      {mode_reg, pwr_reg, up_reg, rdpwr_reg, lock_reg} <= '0;
    end else begin
      rdpwr_reg <= rd && addr == DAAPLS_REG_PWR;
      lock_reg  <= lock_reg | (rdpwr_reg && rdata[DAAPLS_BIT_PLLLOCK]);
      up_reg   <= up_reg + {17'h0_0000, up_reg != 18'h3_FFFF};
      mode_reg <= mode_reg | (wr && (addr == DAAPLS_REG_PCM || addr == DAAPLS_REG_GCI));
      pwr_reg  <= pwr_reg | (wr && addr == DAAPLS_REG_PWR);
    end
  end
  // Bit clock idle time, cleared by each change of level
  always_ff @(posedge clk_i) begin
    bclk_d_reg <= bit_clk;
    bclk_reg   <= (reset_i || bit_clk != bclk_d_reg) ? 8'h00 : bclk_reg + {7'h00, bclk_reg != 8'hFF};
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  a_reset_first: assert property ((wr || rd) |-> reset_n) else $error("access in reset");
  a_lock_wait: assert property (wr |-> lock_reg) else $error("write before lock");
  a_lock_time: assert property ((rdpwr_reg && up_reg > PLL_LOCK_CYC + 4 * CLK_DIV + 4)
    |-> rdata[DAAPLS_BIT_PLLLOCK]) else $error("lock too late");
  a_mode_first: assert property ((wr && addr == DAAPLS_REG_PWR) |-> mode_reg)
    else $error("power write before mode");
  a_power_zero: assert property ((wr && addr == DAAPLS_REG_PWR && !pwr_reg) |-> wdata == 8'h00)
    else $error("first power write not zero");
  a_sleep_linked: assert property ((wr && addr == DAAPLS_REG_PWR && wdata[DAAPLS_BIT_SLEEP])
    |-> pwr_reg && !wdata[DAAPLS_BIT_LSPD]) else $error("sleep before line side up");
  a_cal_armed: assert property ((wr && addr == DAAPLS_REG_CAL && wdata[DAAPLS_BIT_MANUAL_CAL_TRIGGER])
    |-> wdata[DAAPLS_BIT_AUTO_ADC_CAL_DISABLE]) else $error("manual cal with auto cal on");
  a_clock_runs: assert property (bclk_reg <= CLK_DIV) else $error("bit clock stopped");
  a_status_form: assert property ((rd && addr == DAAPLS_REG_STAT) |=> (rdata & 8'hBF) == 8'h00)
    else $error("status bits outside frame detect");
  c_power_up: cover property (wr && addr == DAAPLS_REG_PWR && wdata == 8'h00);
  c_manual: cover property (wr && addr == DAAPLS_REG_CAL && wdata[DAAPLS_BIT_MANUAL_CAL_TRIGGER]);
  c_frame: cover property ($rose(frame_sync));
endmodule

// [testbench/tb.sv]
`timescale 1ns/100ps
// ====================
// Host and device joined over the link
module tb;
  import daapls_pkg::*;
  logic       clk_i, reset_i, start_i, use_gci_i, sleep_i, manual_cal_trigger_i, done_o;  // Host side
  logic       offhook_i, line_power_lost_i, frame_seen_i, ring_i;            // Line side
  logic       link_enable_o, ring_detect_out_o, cal_busy_o;                  // Device flags
  logic [3:0] mode_o;    // One-hot power mode
  logic [7:0] status_o;  // Last status read
  logic [7:0] line_a_i, dcterm_i, acterm_i, line_b_i;  // Country line fields
  logic [7:0] state;     // Mode, link, ring, busy, frame detect
  int         num_errors = 0;
  int         n_tests = 0;
  daapls_link_if link ();
  assign state = {mode_o, link_enable_o, ring_detect_out_o, cal_busy_o, status_o[DAAPLS_BIT_FDT]};
  daapls_host #(.PLL_LOCK_CYC(50)) daapls_host_inst (.clk_i, .reset_i, .link, .start_i, .use_gci_i, .sleep_i,
    .line_a_i, .dcterm_i, .acterm_i, .line_b_i, .manual_cal_trigger_i, .done_o, .status_o);
  daapls_device #(.PLL_LOCK_CYC(50), .RCAL_CYC(40), .ADCCAL_CYC(80)) daapls_device_inst (.clk_i, .reset_i,
    .link, .offhook_i, .line_power_lost_i, .frame_seen_i, .ring_i, .link_enable_o, .ring_detect_out_o,
    .cal_busy_o, .mode_o);
  daapls_asserts #(.PLL_LOCK_CYC(50)) daapls_asserts_inst (.clk_i, .reset_i, .reset_n(link.reset_n),
    .bit_clk(link.bit_clk), .frame_sync(link.frame_sync), .addr(link.addr), .wdata(link.wdata), .wr(link.wr),
    .rd(link.rd), .rdata(link.rdata));
  // Wait n cycles, then compare the packed device state
  task automatic chk(input int n, input string name, input logic [7:0] exp);
    repeat (n) @(posedge clk_i);
    #1;
    n_tests++;
    if (state !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, state);
    end
  endtask
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // Watchdog, the sequence needs under 1500 cycles
  initial begin
    #50000;
    num_errors++;
    finish_test();
  end
  initial begin
    {reset_i, start_i, use_gci_i, sleep_i, manual_cal_trigger_i} = 5'h14;
    {offhook_i, line_power_lost_i, frame_seen_i, ring_i} = 4'h3;
    {line_a_i, dcterm_i, acterm_i, line_b_i} = 32'h00C0_0201;
    repeat (8) @(posedge clk_i);
    reset_i <= 1'b0;
    chk(2, "reset state", 8'h10);
    repeat (30) @(posedge clk_i);
    start_i <= 1'b1;
    // Bounded wait for normal mode with the link up
    for (int i = 0; i < 400 && (state & 8'hF8) !== 8'h28; i++) @(posedge clk_i);
    chk(10, "normal", 8'h2D);
    n_tests++;
    if (done_o !== 1'b1) begin
      num_errors++;
      $display("CHECK FAILED done expected 1 seen %b", done_o);
    end
    @(posedge clk_i) frame_seen_i <= 1'b0;
    chk(8, "no frame", 8'h28);
    @(posedge clk_i) {frame_seen_i, offhook_i} <= 2'h3;
    chk(10, "resistor cal", 8'h2F);
    chk(80, "adc cal", 8'h2F);
    chk(45, "cal done", 8'h2D);
    @(posedge clk_i) {offhook_i, line_power_lost_i} <= 2'h1;
    @(posedge clk_i) line_power_lost_i <= 1'b0;
    chk(10, "power loss cal", 8'h2F);
    for (int i = 0; i < 400 && cal_busy_o !== 1'b0; i++) @(posedge clk_i);
    @(posedge clk_i) manual_cal_trigger_i <= 1'b1;
    for (int i = 0; i < 60 && cal_busy_o !== 1'b1; i++) @(posedge clk_i);
    @(posedge clk_i) manual_cal_trigger_i <= 1'b0;
    chk(70, "manual cal", 8'h2F);
    chk(20, "manual done", 8'h2D);
    @(posedge clk_i) offhook_i <= 1'b1;
    chk(10, "resistor only", 8'h2F);
    chk(50, "adc skipped", 8'h2D);
    @(posedge clk_i) sleep_i <= 1'b1;
    for (int i = 0; i < 60 && mode_o !== DAAPLS_MODE_SLEEP; i++) @(posedge clk_i);
    chk(6, "sleep", 8'h4D);
    @(posedge clk_i) ring_i <= 1'b0;
    chk(6, "sleep ring", 8'h49);
    @(posedge clk_i) {reset_i, sleep_i} <= 2'h2;
    chk(2, "reset again", 8'h10);
    @(posedge clk_i) reset_i <= 1'b0;
    chk(20, "after reset", 8'h10);
    finish_test();
  end
endmodule
